// *** common/rsx_pkg.sv ***
// Constants for the rotate, subtract and exclusive-OR execution subset
package rsx_pkg;
   // ==========================================================
   // Opcodes
   localparam logic [7:0] OP_ROLC   = 8'h33;
   localparam logic [7:0] OP_RORA   = 8'h03;
   localparam logic [7:0] OP_RORC   = 8'h13;
   localparam logic [7:0] OP_SETC   = 8'hD3;
   localparam logic [7:0] OP_SETBIT = 8'hD2;
   localparam logic [7:0] OP_JREL   = 8'h80;
   localparam logic [7:0] OP_SBC_I  = 8'h94;
   localparam logic [7:0] OP_SBC_D  = 8'h95;
   localparam logic [7:0] OP_SBC_P  = 8'h96;
   localparam logic [7:0] OP_SBC_R  = 8'h98;
   localparam logic [7:0] OP_SWAP   = 8'hC4;
   localparam logic [7:0] OP_XCA_D  = 8'hC5;
   localparam logic [7:0] OP_XCA_P  = 8'hC6;
   localparam logic [7:0] OP_XCA_R  = 8'hC8;
   localparam logic [7:0] OP_XDIG   = 8'hD6;
   localparam logic [7:0] OP_EOR_DA = 8'h62;
   localparam logic [7:0] OP_EOR_DI = 8'h63;
   localparam logic [7:0] OP_EOR_I  = 8'h64;
   localparam logic [7:0] OP_EOR_D  = 8'h65;
   localparam logic [7:0] OP_EOR_P  = 8'h66;
   localparam logic [7:0] OP_EOR_R  = 8'h68;
   // Masks for register and pointer forms
   localparam logic [7:0] MSK_REG   = 8'hF8;
   localparam logic [7:0] MSK_PTR   = 8'hFE;
   // ==========================================================
   // Address map
   localparam logic [7:0] PORT_ADDR = 8'h90;
   localparam logic [7:0] SFR_BASE  = 8'h80;
   localparam logic [3:0] BIT_BASE  = 4'h2;
   // ==========================================================
   // Reset values
   localparam logic [15:0] PC_RST   = 16'h0000;
   localparam logic [7:0]  ACC_RST  = 8'h00;
   localparam logic [7:0]  PORT_RST = 8'hFF;
   // ==========================================================
   // Sequencer states
   typedef enum logic {ST_EXEC, ST_WAIT} rsx_state_t;
endpackage

// *** design/rsx_exec.sv ***
// Execution core for the rotate, set, jump, subtract, swap, exchange, xor subset
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Rotate left through carry, one byte
// RULE2 - Rotate accumulator right, carry untouched
// RULE3 - Rotate right through carry, one byte
// RULE4 - Set carry to one, other flags kept
// RULE5 - Set addressed bit to one, flags kept
// RULE6 - Short jump: PC plus two plus displacement
// RULE7 - Jump reach is -128 to +127
// RULE8 - Subtract with borrow; carry is bit-7 borrow
// RULE9 - Half borrow flag from bit 3
// RULE10 - Signed wrap from borrows out of 6, 7
// RULE11 - Subtract decodes register, direct, pointer forms
// RULE12 - Nibble swap of accumulator, flags kept
// RULE13 - Exchange accumulator with operand byte
// RULE14 - Exchange low nibbles with pointed RAM
// RULE15 - Xor on port reads output latch
// RULE16 - Xor into accumulator from four sources
// RULE17 - Xor into direct byte, two forms
// RULE18 - PC advances by instruction byte length
module rsx_exec (
   input  wire logic        mclk,          // Core clock, 250 MHz
   input  wire logic        rstn,          // Async reset, active low
   input  wire logic [23:0] code_bytes,    // Bytes at pc, pc+1, pc+2
   input  wire logic [7:0]  port_pins,     // Output port pin levels
   output logic [15:0]      code_addr_ff,  // Program counter
   output logic [7:0]       acc_ff,        // Accumulator
   output logic             carry_ff,      // Carry flag
   output logic             half_borrow_ff, // Half borrow flag
   output logic             signed_wrap_ff, // Signed wrap flag
   output logic [7:0]       port_latch_ff, // Output port latch
   output logic             bad_op_ff      // Pulse: opcode outside subset
);
   import rsx_pkg::*;

   // ==========================================================
   // Reset release and pin synchronisers
   logic [1:0] rst_sync_ff;  // Reset release chain
   logic       rst_n;        // Synchronised reset
   logic [7:0] pin_s1_ff;    // Pin stage 1
   logic [7:0] pin_s2_ff;    // Pin stage 2
   logic [7:0] pin_s3_ff;    // Pin stage 3
   logic [7:0] pin_ff;       // Accepted pin value

   // Two-flop reset release
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // Three flops; accept once stages two and three agree
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_ff <= 8'h00;
         pin_s2_ff <= 8'h00;
         pin_s3_ff <= 8'h00;
         pin_ff    <= 8'h00;
      end else begin
         pin_s1_ff <= port_pins;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         if (pin_s2_ff == pin_s3_ff) begin
            pin_ff <= pin_s3_ff;
         end
      end
   end

   // ==========================================================
   // Internal RAM, registers of bank 0 at its bottom
   logic [7:0] ram_ff [0:127];  // Lower data RAM
   rsx_state_t st_ff;           // Sequencer state

   // Direct-address read; every source arrives as an argument,
   // so a continuous assignment that calls it sees each change
   function automatic logic [7:0] dir_rd(input logic [7:0] a, input logic [7:0] ram_v,
                                         input logic [7:0] port_v);
      if (a < SFR_BASE) begin
         dir_rd = ram_v;
      end else if (a == PORT_ADDR) begin
         dir_rd = port_v;
      end else begin
         dir_rd = 8'h00;
      end
   endfunction

   // ==========================================================
   // Instruction fields and decode
   wire [7:0] op = code_bytes[7:0];    // Opcode
   wire [7:0] b1 = code_bytes[15:8];   // Second byte
   wire [7:0] b2 = code_bytes[23:16];  // Third byte
   wire       is_rolc   = (op == OP_ROLC);
   wire       is_rora   = (op == OP_RORA);
   wire       is_rorc   = (op == OP_RORC);
   wire       is_setc   = (op == OP_SETC);
   wire       is_setbit = (op == OP_SETBIT);
   wire       is_jrel   = (op == OP_JREL);
   wire       is_swap   = (op == OP_SWAP);
   wire       is_xdig   = ((op & MSK_PTR) == OP_XDIG);
   wire       is_eor_da = (op == OP_EOR_DA);
   wire       is_eor_di = (op == OP_EOR_DI);
   // Subtract in register, direct, pointer and immediate forms
   wire       is_sbc  = ((op & MSK_REG) == OP_SBC_R) || (op == OP_SBC_D)
                        || ((op & MSK_PTR) == OP_SBC_P) || (op == OP_SBC_I); // RULE11
   wire       is_xca  = ((op & MSK_REG) == OP_XCA_R) || (op == OP_XCA_D)
                        || ((op & MSK_PTR) == OP_XCA_P);
   wire       is_eor_a = ((op & MSK_REG) == OP_EOR_R) || (op == OP_EOR_D)
                        || ((op & MSK_PTR) == OP_EOR_P) || (op == OP_EOR_I);
   wire       known = is_rolc | is_rora | is_rorc | is_setc | is_setbit | is_jrel
                      | is_swap | is_xdig | is_eor_da | is_eor_di | is_sbc
                      | is_xca | is_eor_a;
   wire       two_cyc = is_jrel | is_eor_di;  // Two-cycle instructions

   // Byte length per opcode
   wire       len2 = (op == OP_SBC_D) || (op == OP_SBC_I) || is_setbit || is_jrel
                     || (op == OP_XCA_D) || (op == OP_EOR_D) || (op == OP_EOR_I)
                     || is_eor_da;
   wire [15:0] op_len = is_eor_di ? 16'h0003 : (len2 ? 16'h0002 : 16'h0001);

   // ==========================================================
   // Operand fetch, addressing mode from low opcode bits
   wire       m_reg = op[3];
   wire       m_ptr = (op[3:1] == 3'b011);
   wire       m_dir = (op[3:0] == 4'h5);
   wire [6:0] ptr   = ram_ff[{6'h00, op[0]}][6:0];  // Pointer register
   wire [7:0] reg_v = ram_ff[{4'h0, op[2:0]}];      // Work register
   wire [7:0] ind_v = ram_ff[ptr];                  // Pointed RAM byte
   // Exchange reads the latch; plain reads see the pins
   wire [7:0] dir_v = dir_rd(b1, ram_ff[b1[6:0]], is_xca ? port_latch_ff : pin_ff);
   wire [7:0] src_val = m_reg ? reg_v : (m_ptr ? ind_v : (m_dir ? dir_v : b1));
   wire [7:0] opnd_addr = m_reg ? {5'h00, op[2:0]} : (m_ptr ? {1'b0, ptr} : b1);

   // ==========================================================
   // Subtract with borrow arithmetic
   wire [8:0] sub_full = {1'b0, acc_ff} - {1'b0, src_val} - {8'h00, carry_ff}; // RULE8
   wire [4:0] sub_lo = {1'b0, acc_ff[3:0]} - {1'b0, src_val[3:0]}
                       - {4'h0, carry_ff}; // RULE9
   wire [7:0] sub_b6 = {1'b0, acc_ff[6:0]} - {1'b0, src_val[6:0]}
                       - {7'h00, carry_ff};
   wire       wrap = sub_full[8] ^ sub_b6[7]; // RULE10

   // ==========================================================
   // Jump target: signed byte reaches -128..+127 around next PC
   wire [15:0] jmp_tgt = code_addr_ff + 16'h0002 + {{8{b1[7]}}, b1}; // RULE6 RULE7

   // ==========================================================
   // Bit addressing: low half maps to RAM bytes, high to SFR bytes
   wire [7:0] bit_addr = b1[7] ? {b1[7:3], 3'b000} : {BIT_BASE, b1[6:3]};
   wire [7:0] bit_mask = 8'h01 << b1[2:0];
   wire [7:0] bit_old  = dir_rd(bit_addr, ram_ff[bit_addr[6:0]], port_latch_ff);
   // Xor destination reads the latch, never the pins
   wire [7:0] rmw_old  = dir_rd(b1, ram_ff[b1[6:0]], port_latch_ff); // RULE15

   // ==========================================================
   // Commit timing and single write port
   wire commit = (st_ff == ST_WAIT) || !two_cyc;
   wire wr_en  = commit && (is_xca || is_xdig || is_eor_da || is_eor_di || is_setbit);
   wire [7:0] wr_addr = is_xca ? opnd_addr : (is_xdig ? {1'b0, ptr}
                        : (is_setbit ? bit_addr : b1));
   // Write data for each writing form
   wire [7:0] wr_data = is_xca ? acc_ff // RULE13
                        : is_xdig ? {ind_v[7:4], acc_ff[3:0]} // RULE14
                        : is_setbit ? (bit_old | bit_mask) // RULE5
                        : is_eor_da ? (rmw_old ^ acc_ff) // RULE17
                        : (rmw_old ^ b2); // RULE17
   wire wr_ram  = wr_en && (wr_addr < SFR_BASE);
   wire wr_port = wr_en && (wr_addr == PORT_ADDR);

   // ==========================================================
   // Next accumulator and flags
   wire [7:0] nxt_acc = is_rolc ? {acc_ff[6:0], carry_ff} // RULE1
                        : is_rora ? {acc_ff[0], acc_ff[7:1]} // RULE2
                        : is_rorc ? {carry_ff, acc_ff[7:1]} // RULE3
                        : is_sbc ? sub_full[7:0] // RULE8
                        : is_swap ? {acc_ff[3:0], acc_ff[7:4]} // RULE12
                        : is_xca ? src_val // RULE13
                        : is_xdig ? {acc_ff[7:4], ind_v[3:0]} // RULE14
                        : is_eor_a ? (acc_ff ^ src_val) // RULE16
                        : acc_ff;
   wire nxt_carry = is_rolc ? acc_ff[7] // RULE1
                    : is_rorc ? acc_ff[0] // RULE3
                    : is_setc ? 1'b1 // RULE4
                    : is_sbc ? sub_full[8] // RULE8
                    : carry_ff;
   wire [15:0] nxt_pc = is_jrel ? jmp_tgt : (code_addr_ff + op_len); // RULE18

   // Sequencer: two-cycle forms wait one cycle, then commit
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_EXEC;
      end else begin
         case (st_ff)
            // Hold back the commit of a two-cycle form by one edge
            ST_EXEC: st_ff <= two_cyc ? ST_WAIT : ST_EXEC;
            default: st_ff <= ST_EXEC;
         endcase
      end
   end

   // Architectural state update on commit
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         code_addr_ff   <= PC_RST;
         acc_ff         <= ACC_RST;
         carry_ff       <= 1'b0;
         half_borrow_ff <= 1'b0;
         signed_wrap_ff <= 1'b0;
         bad_op_ff      <= 1'b0;
      end else begin
         bad_op_ff <= commit && !known;
         if (commit) begin
            code_addr_ff <= nxt_pc;
            acc_ff       <= nxt_acc;
            carry_ff     <= nxt_carry;
            // Only subtract touches the two extra flags
            if (is_sbc) begin
               half_borrow_ff <= sub_lo[4]; // RULE9
               signed_wrap_ff <= wrap; // RULE10
            end
         end
      end
   end

   // Port latch written by exchange, bit set and xor
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         port_latch_ff <= PORT_RST;
      end else if (wr_port) begin
         port_latch_ff <= wr_data; // RULE15
      end
   end

   // RAM write, no reset on storage
   always_ff @(posedge mclk) begin
      if (wr_ram) begin
         ram_ff[wr_addr[6:0]] <= wr_data;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_rolc;
      commit && is_rolc |=> acc_ff == {$past(acc_ff[6:0]), $past(carry_ff)}
         && carry_ff == $past(acc_ff[7]);
   endproperty
   a_rolc: assert property (p_rolc) else $error("rotate left carry wrong"); // RULE1
   property p_rora;
      commit && is_rora |=> acc_ff == {$past(acc_ff[0]), $past(acc_ff[7:1])}
         && $stable(carry_ff);
   endproperty
   a_rora: assert property (p_rora) else $error("rotate right wrong"); // RULE2
   property p_rorc;
      commit && is_rorc |=> acc_ff == {$past(carry_ff), $past(acc_ff[7:1])}
         && carry_ff == $past(acc_ff[0]);
   endproperty
   a_rorc: assert property (p_rorc) else $error("rotate right carry wrong"); // RULE3
   property p_setc;
      commit && is_setc |=> carry_ff && $stable(acc_ff) && $stable(signed_wrap_ff);
   endproperty
   a_setc: assert property (p_setc) else $error("carry not set"); // RULE4
   property p_jrel;
      is_jrel && st_ff == ST_EXEC |-> ##2 code_addr_ff == $past(jmp_tgt, 2);
   endproperty
   a_jrel: assert property (p_jrel) else $error("short jump target wrong"); // RULE6
   property p_sbc;
      commit && is_sbc |=> {carry_ff, acc_ff} == {1'b0, $past(acc_ff)}
         - {1'b0, $past(src_val)} - {8'h00, $past(carry_ff)};
   endproperty
   a_sbc: assert property (p_sbc) else $error("subtract result wrong"); // RULE8
   property p_half;
      commit && is_sbc |=> half_borrow_ff == ({1'b0, $past(acc_ff[3:0])}
         < {1'b0, $past(src_val[3:0])} + {4'h0, $past(carry_ff)});
   endproperty
   a_half: assert property (p_half) else $error("half borrow wrong"); // RULE9
   // Signed wrap: operand signs differ and the result sign left the minuend's
   property p_wrap;
      commit && is_sbc |=> signed_wrap_ff == (($past(acc_ff[7]) != $past(src_val[7]))
         && (acc_ff[7] != $past(acc_ff[7])));
   endproperty
   a_wrap: assert property (p_wrap) else $error("signed wrap wrong"); // RULE10
   property p_swap;
      commit && is_swap |=> acc_ff == {$past(acc_ff[3:0]), $past(acc_ff[7:4])}
         && $stable(carry_ff);
   endproperty
   a_swap: assert property (p_swap) else $error("nibble swap wrong"); // RULE12
   // Low digit comes in from the pointed byte, high digit and carry stay
   property p_xdig;
      commit && is_xdig |=> acc_ff == {$past(acc_ff[7:4]), $past(ind_v[3:0])}
         && $stable(carry_ff);
   endproperty
   a_xdig: assert property (p_xdig) else $error("low digit exchange wrong"); // RULE14
   property p_latch;
      is_eor_di && b1 == PORT_ADDR && st_ff == ST_WAIT
         |=> port_latch_ff == ($past(port_latch_ff) ^ $past(b2));
   endproperty
   a_latch: assert property (p_latch) else $error("port xor not from latch"); // RULE15
   property p_eor;
      commit && is_eor_a |=> acc_ff == ($past(acc_ff) ^ $past(src_val)) && $stable(carry_ff);
   endproperty
   a_eor: assert property (p_eor) else $error("xor into accumulator wrong"); // RULE16
   property p_len;
      commit && !is_jrel |=> code_addr_ff == $past(code_addr_ff) + $past(op_len);
   endproperty
   a_len: assert property (p_len) else $error("pc step wrong"); // RULE18
endmodule

// *** test/rsx_exec_test.sv ***
// Self-checking bench for the rotate, subtract, exchange and xor core
`timescale 1ns/1ps
module rsx_exec_test;
   import rsx_pkg::*;
   // ==========
   // Signals and model state
   logic        mclk;            // Core clock
   logic        rstn;            // Reset, active low
   logic [7:0]  port_pins;       // Pin levels
   logic [23:0] code_bytes;      // Bytes at pc..pc+2
   logic [15:0] code_addr_ff;    // Core program counter
   logic [7:0]  acc_ff;          // Core accumulator
   logic        carry_ff;        // Core flags
   logic        half_borrow_ff;
   logic        signed_wrap_ff;
   logic [7:0]  port_latch_ff;   // Core port latch
   logic        bad_op_ff;       // Skip pulse
   logic [7:0]  mem [65536];     // Program memory
   logic [7:0]  m_ram [128];     // Model internal RAM
   logic [15:0] m_pc;            // Model counter
   logic [7:0]  m_acc, m_lat, pins_m, v, op;
   logic        m_c, m_hb, m_sw, m_bad;
   int          fail_count, n_tests, cyc_count;
   logic [7:0]  ld_a [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8'h21, 8'h30, 8'h45};
   logic [7:0]  rnd_op [8] = '{8'h64, 8'h33, 8'h03, 8'h13, 8'hD3, 8'hC4, 8'h94, 8'h80};

   // Memory answers in the same cycle as the counter
   assign code_bytes = {mem[code_addr_ff + 16'd2], mem[code_addr_ff + 16'd1], mem[code_addr_ff]};

   rsx_exec rsx_exec_i (
      .mclk           (mclk),
      .rstn           (rstn),
      .code_bytes     (code_bytes),
      .port_pins      (port_pins),
      .code_addr_ff   (code_addr_ff),
      .acc_ff         (acc_ff),
      .carry_ff       (carry_ff),
      .half_borrow_ff (half_borrow_ff),
      .signed_wrap_ff (signed_wrap_ff),
      .port_latch_ff  (port_latch_ff),
      .bad_op_ff      (bad_op_ff)
   );

   // Free-running clock, 4 ns
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Hang guard
   always @(posedge mclk) begin
      cyc_count++;
      if (cyc_count == 5000) begin
         fail_count++;
         wrap_up();
      end
   end

   // ==========
   // Checking
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      if (^exp === 1'bx) return;   // Unknown model value, skip
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_all;
      chk(code_addr_ff, m_pc);
      chk(16'(acc_ff), 16'(m_acc));
      chk(16'(carry_ff), 16'(m_c));
      chk(16'(half_borrow_ff), 16'(m_hb));
      chk(16'(signed_wrap_ff), 16'(m_sw));
      chk(16'(port_latch_ff), 16'(m_lat));
      chk(16'(bad_op_ff), 16'(m_bad));
   endtask

   task wrap_up;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ==========
   // Reference model
   function automatic logic [7:0] rd(input int ea, input logic pin);
      if (ea < 128) return m_ram[ea];
      if (ea == 'h90) return pin ? pins_m : m_lat;
      return 8'h00;   // Other special bytes read zero
   endfunction

   task automatic wr(input int ea, input logic [7:0] d);
      if (ea < 128) m_ram[ea] = d;
      else if (ea == 'h90) m_lat = d;
   endtask

   // Places one instruction at the model counter, runs it, compares
   task automatic step(input logic [7:0] b0, input logic [7:0] b1 = 8'h00,
                       input logic [7:0] b2 = 8'h00);
      int         ea, n, cy;
      logic [7:0] s;
      logic [8:0] d9;
      logic [7:0] d7;
      logic [4:0] d4;
      mem[m_pc] = b0;
      mem[m_pc + 16'd1] = b1;
      mem[m_pc + 16'd2] = b2;
      if (b0[3]) ea = b0[2:0];                                // Work register
      else if (b0[3:1] == 3'b011) ea = m_ram[b0[0]][6:0];    // Pointer
      else ea = b1;                                          // Direct
      n = (b0[3:1] == 3'b010) ? 2 : 1;
      cy = 1;
      m_bad = 1'b0;
      // Only forms that leave the port alone read its pins
      s = (b0[3:0] == 4'h4) ? b1 : rd(ea, (b0[7:4] == 4'h9) || (b0 == 8'h65));
      casez (b0)
         8'h33: {m_c, m_acc} = {m_acc, m_c};
         8'h03: m_acc = {m_acc[0], m_acc[7:1]};
         8'h13: {m_acc, m_c} = {m_c, m_acc};
         8'hD3: m_c = 1'b1;
         8'hC4: begin n = 1; m_acc = {m_acc[3:0], m_acc[7:4]}; end
         8'hD2: begin
            n = 2;
            if (!b1[7]) m_ram[8'h20 + b1[6:3]][b1[2:0]] = 1'b1;
            else if (b1[7:3] == 5'h12) m_lat[b1[2:0]] = 1'b1;
         end
         8'h80: begin n = 0; cy = 2; m_pc = m_pc + 16'd2 + {{8{b1[7]}}, b1}; end
         8'h94, 8'h95, 8'h96, 8'h97, 8'b1001_1???: begin
            d9 = {1'b0, m_acc} - {1'b0, s} - 9'(m_c);
            d7 = {1'b0, m_acc[6:0]} - {1'b0, s[6:0]} - 8'(m_c);
            d4 = {1'b0, m_acc[3:0]} - {1'b0, s[3:0]} - 5'(m_c);
            m_hb = d4[4];
            m_sw = d9[8] ^ d7[7];
            m_c = d9[8];
            m_acc = d9[7:0];
         end
         8'hC5, 8'hC6, 8'hC7, 8'b1100_1???: begin wr(ea, m_acc); m_acc = s; end
         8'hD6, 8'hD7: begin
            wr(ea, {s[7:4], m_acc[3:0]});
            m_acc = {m_acc[7:4], s[3:0]};
         end
         8'h64, 8'h65, 8'h66, 8'h67, 8'b0110_1???: m_acc = m_acc ^ s;
         8'h62: begin n = 2; wr(ea, rd(ea, 1'b0) ^ m_acc); end
         8'h63: begin n = 3; cy = 2; wr(ea, rd(ea, 1'b0) ^ b2); end
         default: begin n = 1; m_bad = 1'b1; end
      endcase
      m_pc = m_pc + 16'(n);
      repeat (cy) @(posedge mclk);
      #1;
      chk_all();
   endtask

   // ==========
   // Main sequence
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
      rstn = 1'b0;
      port_pins = 8'h00;
      n_tests = 0;
      fail_count = 0;
      cyc_count = 0;
      m_pc = PC_RST;
      m_acc = ACC_RST;
      m_lat = PORT_RST;
      {m_c, m_hb, m_sw, m_bad} = 4'h0;
      void'($urandom(40802));
      pins_m = 8'($urandom);
      @(posedge mclk);
      port_pins <= pins_m;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk_all();   // Reset values
      // Preload registers and RAM through the accumulator
      for (int i = 0; i < 11; i++) begin
         v = (i < 2) ? 8'(8'h30 - i * 15) : 8'($urandom);
         step(8'h64, v);
         step(8'hC5, ld_a[i]);
         step(8'hC5, 8'hA0);
      end
      // Rotates, carry set and nibble swap back to back
      for (int i = 0; i < 8; i++) begin
         step(8'h64, 8'($urandom));
         if (i[0]) step(8'hD3);
         step(8'h33);
         step(8'h03);
         step(8'h13);
         step(8'hC4);
      end
      // Every subtract form, carry in both states, pins as source
      for (int i = 0; i < 13; i++) begin
         op = (i == 12) ? 8'h95 : 8'(8'h94 + i);
         v = (i == 12) ? PORT_ADDR : ((i == 1) ? 8'h45 : 8'($urandom));
         step(8'h64, 8'($urandom));
         step(i[0] ? 8'hD3 : 8'h33);
         step(op, v);
      end
      // Exchanges done twice, so pointers survive
      for (int i = 0; i < 14; i++) begin
         op = (i < 11) ? 8'(8'hC5 + i) : ((i < 13) ? 8'(8'hCB + i) : 8'hC5);
         v = (i == 13) ? PORT_ADDR : 8'h30;
         step(8'h64, 8'($urandom));
         step(op, v);
         step(op, v);
      end
      // Xor into accumulator from every source, then into direct bytes
      for (int i = 0; i < 12; i++)
         step(8'(8'h64 + i), (i == 0) ? 8'($urandom) : ((i == 1) ? PORT_ADDR : 8'h45));
      step(8'h62, 8'h45);
      step(8'h62, PORT_ADDR);
      step(8'h63, 8'h45, 8'($urandom));
      step(8'h63, PORT_ADDR, 8'($urandom));
      step(8'h65, 8'h45);
      // Bit set in RAM, on the port and on an inert byte
      step(8'hD2, 8'h0B);
      step(8'h65, 8'h21);
      step(8'hD2, 8'h93);
      step(8'hD2, 8'hE0);
      // Jump reach at both ends and a self loop
      foreach (ld_a[i]) step(8'h80, i[0] ? 8'h7F : (i[1] ? 8'h80 : 8'hFE));
      // Opcodes outside the subset
      step(8'hA5);
      step(8'h00);
      // Random mix of accumulator, carry-set and jump operations
      for (int i = 0; i < 150; i++)
         step(rnd_op[$urandom % 8], 8'($urandom));
      wrap_up();
   end
endmodule
